// ---- include/sfp_regs.svh ----
// Timing counts and command encodings for the serial flash power-up and framing block.
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH
`define SFP_CLK_MHZ          50
`define SFP_VCSL_US          70
`define SFP_VCSL_CYC         (`SFP_VCSL_US * `SFP_CLK_MHZ)
`define SFP_PUW_MS           3
`define SFP_PUW_CYC          (`SFP_PUW_MS * 1000 * `SFP_CLK_MHZ)
`define SFP_SCK_HALF         4
`define SFP_OP_PAGE_READ     8'hD2
`define SFP_OP_BUF1_READ     8'hD4
`define SFP_OP_BUF2_READ     8'hD6
`define SFP_OP_BUF_READ_LF   8'hD3
`define SFP_OP_STATUS        8'hD7
`define SFP_ADDR_BITS        24
`define SFP_DUMMY_PAGE       3
`define SFP_PAGE_BITS        12
`define SFP_BYTE_BITS        9
`define SFP_DUMMY_BUF        15
`endif

// ---- include/sfp_pkg.sv ----
// State types for each end and the command type shared by both ends of the serial flash link.
package sfp_pkg;
    typedef enum logic [3:0] {
        SFP_POR    = 4'b0001,
        SFP_IDLE   = 4'b0010,
        SFP_OPCODE = 4'b0100,
        SFP_ADDR   = 4'b1000
    } sfp_dev_state_t;
    typedef enum logic [3:0] {
        SFP_H_WAIT = 4'b0001,
        SFP_H_IDLE = 4'b0010,
        SFP_H_SHIFT = 4'b0100,
        SFP_H_DONE = 4'b1000
    } sfp_host_state_t;
    typedef struct packed {
        logic [7:0]  opcode;
        logic [11:0] page;
        logic [8:0]  byte_addr;
    } sfp_cmd_t;
endpackage

// ---- include/sfp_link_if.sv ----
// Interface carrying select, serial clock, serial input and serial output between host and flash.
`timescale 1ns/100ps
interface sfp_link_if;
    logic select_n_pin; // Active low chip select from host.
    logic sck;          // Serial clock from host.
    logic si;           // Serial data into flash.
    logic so_out;       // Flash serial output value.
    logic so_oe_n;      // Flash output enable, low while driving.
    modport device (input select_n_pin, input sck, input si, output so_out, output so_oe_n);
    modport host   (output select_n_pin, output sck, output si, input so_out, input so_oe_n);
endinterface

// ---- design/sfp_device.sv ----
// Flash end: power-up hold-off, SPI mode pick and command framing of the D2h..D7h opcodes.
`timescale 1ns/100ps
`include "sfp_regs.svh"
module sfp_device #(
    parameter int PUW_CYC = `SFP_PUW_CYC // Power-up write delay in cycles.
) (
    input  wire logic        clock,        // System clock.
    input  wire logic        resetn,       // Asynchronous reset, active low.
    sfp_link_if.device       link,         // Link to host.
    input  wire logic        por_active,   // Internal power-on reset asserted.
    output sfp_pkg::sfp_cmd_t cmd,         // Last framed command.
    output logic             cmd_valid,    // One-cycle pulse on complete command.
    output logic             mode3,        // SPI mode picked at last select fall.
    output logic             standby,      // Ready and deselected.
    output logic             active,       // Ready and selected.
    output logic             write_ready   // Power-up write delay elapsed.
);
    import sfp_pkg::*;

    logic [2:0] sck_s, cs_s, si_s;
    logic [2:0] next_sck_s, next_cs_s, next_si_s;
    sfp_dev_state_t state, next_state;
    logic [7:0]  opcode, next_opcode;
    logic [23:0] addr, next_addr;
    logic [4:0]  cnt, next_cnt;
    logic [31:0] puw, next_puw;
    sfp_cmd_t    next_cmd;
    logic        next_cmd_valid, next_mode3, next_write_ready;
    logic        cs_fall, cs_rise, sck_edge, sample;

    always_comb begin
        next_sck_s = {sck_s[1:0], link.sck};
        next_cs_s  = {cs_s[1:0], link.select_n_pin};
        next_si_s  = {si_s[1:0], link.si};
    end

    assign cs_fall  = cs_s[2] & ~cs_s[1];
    assign cs_rise  = ~cs_s[2] & cs_s[1];
    // Mode 0 and 3 both sample on the rising clock edge.
    assign sck_edge = ~sck_s[2] & sck_s[1];
    assign sample   = sck_edge & ~cs_s[1];

    always_comb begin
        next_state       = state;
        next_opcode      = opcode;
        next_addr        = addr;
        next_cnt         = cnt;
        next_cmd         = cmd;
        next_cmd_valid   = 1'b0;
        next_mode3       = mode3;
        next_puw         = puw;
        next_write_ready = write_ready;
        if (!write_ready) begin
            if (puw == 32'(PUW_CYC - 1)) begin
                next_write_ready = 1'b1;
            end else begin
                next_puw = puw + 32'd1;
            end
        end
        case (state)
            SFP_POR: begin
                if (!por_active) begin
                    next_state = SFP_IDLE;
                end
            end
            SFP_IDLE: begin
                if (cs_fall) begin
                    next_mode3 = sck_s[1];
                    next_cnt   = 5'd0;
                    next_state = SFP_OPCODE;
                end
            end
            SFP_OPCODE: begin
                if (sample) begin
                    next_opcode = {opcode[6:0], si_s[1]};
                    if (cnt == 5'd7) begin
                        next_cnt = 5'd0;
                        if ({opcode[6:0], si_s[1]} == `SFP_OP_STATUS) begin
                            next_cmd       = '{opcode: `SFP_OP_STATUS, page: 12'h000, byte_addr: 9'h000};
                            next_cmd_valid = 1'b1;
                            next_state     = SFP_IDLE;
                        end else begin
                            next_state = SFP_ADDR;
                        end
                    end else begin
                        next_cnt = cnt + 5'd1;
                    end
                end
            end
            SFP_ADDR: begin
                if (sample) begin
                    next_addr = {addr[22:0], si_s[1]};
                    if (cnt == 5'(`SFP_ADDR_BITS - 1)) begin
                        next_cmd.opcode    = opcode;
                        next_cmd.byte_addr = next_addr[8:0];
                        if (opcode == `SFP_OP_PAGE_READ) begin
                            next_cmd.page = next_addr[20:9];
                        end else begin
                            next_cmd.page = 12'h000;
                        end
                        next_cmd_valid = 1'b1;
                        next_state     = SFP_IDLE;
                    end else begin
                        next_cnt = cnt + 5'd1;
                    end
                end
            end
            default: begin
                next_state = SFP_POR;
            end
        endcase
        if (por_active) begin
            next_state     = SFP_POR;
            next_cmd_valid = 1'b0;
        end else if (cs_rise && state != SFP_POR) begin
            next_state = SFP_IDLE;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sck_s       <= 3'h0;
            cs_s        <= 3'h7;
            si_s        <= 3'h0;
            state       <= SFP_POR;
            opcode      <= 8'h00;
            addr        <= 24'h00_0000;
            cnt         <= 5'd0;
            cmd         <= '0;
            cmd_valid   <= 1'b0;
            mode3       <= 1'b0;
            puw         <= 32'h0000_0000;
            write_ready <= 1'b0;
        end else begin
            sck_s       <= next_sck_s;
            cs_s        <= next_cs_s;
            si_s        <= next_si_s;
            state       <= next_state;
            opcode      <= next_opcode;
            addr        <= next_addr;
            cnt         <= next_cnt;
            cmd         <= next_cmd;
            cmd_valid   <= next_cmd_valid;
            mode3       <= next_mode3;
            puw         <= next_puw;
            write_ready <= next_write_ready;
        end
    end

    assign standby      = write_ready & cs_s[1];
    assign active       = write_ready & ~cs_s[1];
    assign link.so_out  = 1'b0;
    assign link.so_oe_n = 1'b1;
endmodule

// ---- design/sfp_host.sv ----
// Host end: power-up timer, then framing of one command per request onto the link.
`timescale 1ns/100ps
`include "sfp_regs.svh"
module sfp_host #(
    parameter int PUW_CYC  = `SFP_PUW_CYC,  // Wait before any command.
    parameter int HALF_CYC = `SFP_SCK_HALF  // Serial clock half period in cycles.
) (
    input  wire logic         clock,     // System clock.
    input  wire logic         resetn,    // Asynchronous reset, active low.
    sfp_link_if.host          link,      // Link to flash.
    input  wire logic         req,       // Request a command, level held until ack.
    input  sfp_pkg::sfp_cmd_t req_cmd,   // Command to send.
    output logic              ack,       // One-cycle pulse when frame ends.
    output logic              ready      // Power-up timer done and idle.
);
    import sfp_pkg::*;

    sfp_host_state_t state, next_state;
    logic [31:0] timer, next_timer;
    logic [7:0]  half, next_half;
    logic [5:0]  nbits, next_nbits, bit_idx, next_bit_idx;
    logic [31:0] shreg, next_shreg;
    logic        sck_r, next_sck, si_r, next_si, cs_r, next_cs, next_ack;
    logic [23:0] frame_addr;

    // Page-type opcodes carry page and byte; buffer ones carry the byte only.
    always_comb begin
        if (req_cmd.opcode == `SFP_OP_PAGE_READ) begin
            frame_addr = {3'b000, req_cmd.page, req_cmd.byte_addr};
        end else begin
            frame_addr = {15'h0000, req_cmd.byte_addr};
        end
    end

    always_comb begin
        next_state   = state;
        next_timer   = timer;
        next_half    = half;
        next_nbits   = nbits;
        next_bit_idx = bit_idx;
        next_shreg   = shreg;
        next_sck     = sck_r;
        next_si      = si_r;
        next_cs      = cs_r;
        next_ack     = 1'b0;
        case (state)
            SFP_H_WAIT: begin
                next_cs = 1'b1;
                if (timer == 32'(PUW_CYC - 1)) begin
                    next_state = SFP_H_IDLE;
                end else begin
                    next_timer = timer + 32'd1;
                end
            end
            SFP_H_IDLE: begin
                if (req) begin
                    next_shreg = {req_cmd.opcode, frame_addr};
                    next_nbits = (req_cmd.opcode == `SFP_OP_STATUS) ? 6'd8 : 6'd32;
                    next_bit_idx = 6'd0;
                    next_cs    = 1'b0;
                    next_sck   = 1'b0;
                    next_si    = req_cmd.opcode[7];
                    next_half  = 8'd0;
                    next_state = SFP_H_SHIFT;
                end
            end
            SFP_H_SHIFT: begin
                if (half == 8'(HALF_CYC - 1)) begin
                    next_half = 8'd0;
                    next_sck  = ~sck_r;
                    if (sck_r) begin
                        if (bit_idx == nbits - 6'd1) begin
                            next_state = SFP_H_DONE;
                        end else begin
                            next_bit_idx = bit_idx + 6'd1;
                            next_shreg   = {shreg[30:0], 1'b0};
                            next_si      = shreg[30];
                        end
                    end
                end else begin
                    next_half = half + 8'd1;
                end
            end
            SFP_H_DONE: begin
                if (half == 8'(HALF_CYC - 1)) begin
                    next_cs    = 1'b1;
                    next_ack   = 1'b1;
                    next_half  = 8'd0;
                    next_state = SFP_H_IDLE;
                end else begin
                    next_half = half + 8'd1;
                end
            end
            default: begin
                next_state = SFP_H_WAIT;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state   <= SFP_H_WAIT;
            timer   <= 32'h0000_0000;
            half    <= 8'h00;
            nbits   <= 6'd0;
            bit_idx <= 6'd0;
            shreg   <= 32'h0000_0000;
            sck_r   <= 1'b0;
            si_r    <= 1'b0;
            cs_r    <= 1'b1;
            ack     <= 1'b0;
        end else begin
            state   <= next_state;
            timer   <= next_timer;
            half    <= next_half;
            nbits   <= next_nbits;
            bit_idx <= next_bit_idx;
            shreg   <= next_shreg;
            sck_r   <= next_sck;
            si_r    <= next_si;
            cs_r    <= next_cs;
            ack     <= next_ack;
        end
    end

    assign ready             = (state == SFP_H_IDLE);
    assign link.select_n_pin = cs_r;
    assign link.sck          = sck_r;
    assign link.si           = si_r;
endmodule

// ---- bench/sfp_link_chk_sva.sv ----
// Link-level checker for the host and flash ends of the serial flash link.
`timescale 1ns/100ps
module sfp_link_chk #(
    parameter int PUW_CYC = 20 // Host power-up wait in cycles.
) (
    input wire logic clock,        // System clock.
    input wire logic resetn,       // Asynchronous reset, active low.
    input wire logic select_n_pin, // Chip select, active low.
    input wire logic sck,          // Serial clock.
    input wire logic si,           // Serial data into flash.
    input wire logic so_out,       // Flash output value.
    input wire logic so_oe_n       // Flash output enable, active low.
);
    logic [31:0] pcnt;
    logic [5:0]  nrise;
    logic [31:0] sh;
    logic        sck_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Counts cycles since reset up to PUW_CYC + 2, and sampled clock rises within the current frame.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pcnt  <= '0;
            nrise <= '0;
            sh    <= '0;
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck;
            if (pcnt < PUW_CYC + 2) pcnt <= pcnt + 1;
            if (select_n_pin) nrise <= '0;
            else if (sck && !sck_q) begin
                nrise <= nrise + 1;
                sh    <= {sh[30:0], si};
            end
        end
    end
    property p_so_tristate; so_oe_n; endproperty
    a_so_tristate: assert property (p_so_tristate) else $error("flash drove its output");
    property p_wait_power; pcnt < PUW_CYC |-> select_n_pin; endproperty
    a_wait_power: assert property (p_wait_power) else $error("select low before power-up wait");
    property p_mode_pick; $fell(select_n_pin) |-> !sck; endproperty
    a_mode_pick: assert property (p_mode_pick) else $error("clock not idle low at select fall");
    property p_idle_clock; select_n_pin && $past(select_n_pin) |-> !sck; endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("clock moved while deselected");
    property p_frame_len;
        $rose(select_n_pin) |-> (nrise == 8 && sh[7:0] == 8'hD7) || (nrise == 32 && sh[31:24] != 8'hD7);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length does not fit opcode");
    property p_edge_in_frame; $rose(sck) |-> !select_n_pin; endproperty
    a_edge_in_frame: assert property (p_edge_in_frame) else $error("clock rose while deselected");
    property p_select_hold; $fell(select_n_pin) |=> !select_n_pin [*8]; endproperty
    a_select_hold: assert property (p_select_hold) else $error("select released too early");
    property p_si_stable; $rose(sck) |-> $stable(si); endproperty
    a_si_stable: assert property (p_si_stable) else $error("data moved at sampling edge");
endmodule

// ---- bench/tb.sv ----
// Testbench joining host and flash ends and checking framed commands.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, a); end end
module tb;
    import sfp_pkg::*;
    logic      clock;
    logic      resetn;
    logic      req;
    logic      por_active;
    logic      got;
    sfp_cmd_t  req_cmd;
    sfp_cmd_t  cmd;
    logic      cmd_valid, mode3, standby, active, write_ready, ack, ready;
    int        num_errors;
    int        n_compared;
    int        por_pulse_at;
    sfp_link_if link ();
    sfp_host #(.PUW_CYC(20), .HALF_CYC(4)) sfp_host_i (.clock(clock), .resetn(resetn), .link(link), .req(req),
        .req_cmd(req_cmd), .ack(ack), .ready(ready));
    sfp_device #(.PUW_CYC(20)) sfp_device_i (.clock(clock), .resetn(resetn), .link(link), .por_active(por_active),
        .cmd(cmd), .cmd_valid(cmd_valid), .mode3(mode3), .standby(standby), .active(active),
        .write_ready(write_ready));
    sfp_link_chk #(.PUW_CYC(20)) sfp_link_chk_i (.clock(clock), .resetn(resetn), .select_n_pin(link.select_n_pin),
        .sck(link.sck), .si(link.si), .so_out(link.so_out), .so_oe_n(link.so_oe_n));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) if (cmd_valid === 1'b1) got <= 1'b1;
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Sends one command through the host and checks what the flash end framed.
    task automatic send(input sfp_cmd_t c, input logic exp_valid);
        int n;
        n = 0;
        got = 1'b0;
        req = 1'b1;
        req_cmd = c;
        while (ack !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
            // A mid-frame internal reset pulse must leave the rest of the frame ignored.
            if (por_pulse_at > 0 && n == por_pulse_at) begin
                por_active = 1'b1;
            end
            if (por_pulse_at > 0 && n == por_pulse_at + 4) begin
                por_active = 1'b0;
            end
            if (n == 20) begin
                `CHK("active", 1'b1, active)
                `CHK("mode3", 1'b0, mode3)
            end
        end
        req = 1'b0;
        if (n >= 2000) num_errors++;
        repeat (8) @(negedge clock);
        `CHK("cmd_valid", exp_valid, got)
        if (exp_valid) begin
            `CHK("opcode", c.opcode, cmd.opcode)
            if (c.opcode != 8'hD7) begin
                `CHK("page", (c.opcode == 8'hD2) ? c.page : 12'h000, cmd.page)
                `CHK("byte", c.byte_addr, cmd.byte_addr)
            end
        end
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        repeat (4) @(negedge clock);
        `CHK("so_oe_n", 1'b1, link.so_oe_n)
        `CHK("write_ready", 1'b0, write_ready)
        `CHK("cmd", 29'h0000_0000, cmd)
        resetn = 1'b1;
        repeat (10) @(negedge clock);
        `CHK("standby_early", 1'b0, standby)
        `CHK("ready_early", 1'b0, ready)
        `CHK("select_early", 1'b1, link.select_n_pin)
        repeat (14) @(negedge clock);
        `CHK("standby", 1'b1, standby)
        `CHK("active", 1'b0, active)
        `CHK("write_ready_late", 1'b1, write_ready)
        `CHK("ready", 1'b1, ready)
    endtask
    initial begin
        sfp_cmd_t tbl [6];
        tbl = '{{8'hD2, 12'hFFF, 9'h1FF}, {8'hD2, 12'h5A3, 9'h000}, {8'hD3, 12'hABC, 9'h155},
                {8'hD4, 12'hFFF, 9'h1FF}, {8'hD6, 12'h123, 9'h0AA}, {8'hD7, 12'h000, 9'h000}};
        num_errors = 0;
        n_compared = 0;
        req = 1'b0;
        req_cmd = '0;
        por_active = 1'b0;
        por_pulse_at = 0;
        got = 1'b0;
        do_reset();
        por_active = 1'b1;
        send(tbl[0], 1'b0);
        por_active = 1'b0;
        foreach (tbl[i]) send(tbl[i], 1'b1);
        por_pulse_at = 100;
        send(tbl[1], 1'b0);
        por_pulse_at = 0;
        send(tbl[4], 1'b1);
        do_reset();
        send(tbl[2], 1'b1);
        report_and_stop();
    end
    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
endmodule
